// ### acd_pkg.sv
// Package with register map, field layout and encodings of the comparator control block
package acd_pkg;

    // Register indices; byte address is four times the index
    localparam logic [1:0] ACD_IDX_CTRL_STATUS = 2'h0;
    localparam logic [1:0] ACD_IDX_INPUT_SEL   = 2'h1;
    localparam logic [1:0] ACD_IDX_DAC_CTRL    = 2'h2;
    localparam logic [1:0] ACD_IDX_PAD_EN      = 2'h3;
    localparam int         ACD_ADDR_SCALE      = 4;
    localparam logic [11:0] ACD_ADDR_CTRL_STATUS = 12'h000;
    localparam logic [11:0] ACD_ADDR_INPUT_SEL   = 12'h004;
    localparam logic [11:0] ACD_ADDR_DAC_CTRL    = 12'h008;
    localparam logic [11:0] ACD_ADDR_PAD_EN      = 12'h00c;

    // Reset value shared by all four registers
    localparam logic [7:0] ACD_RESET_VALUE = 8'h00;

    // Control and status register fields
    localparam int ACD_CS_ENABLE_BIT = 7;
    localparam int ACD_CS_HYST_BIT   = 6;
    localparam int ACD_CS_FLAG_BIT   = 5;
    localparam int ACD_CS_IRQEN_BIT  = 4;
    localparam int ACD_CS_OUT_BIT    = 3;
    localparam int ACD_CS_OPE_BIT    = 2;
    localparam int ACD_CS_MODE_LSB   = 0;

    // Input select fields
    localparam int ACD_SEL_POS_LSB = 4;
    localparam int ACD_SEL_NEG_LSB = 0;

    // DAC control fields
    localparam int ACD_DAC_EN_BIT   = 7;
    localparam int ACD_DAC_REF_BIT  = 6;
    localparam int ACD_DAC_CODE_LSB = 0;

    // Pad enable field
    localparam int ACD_PAD_LSB = 0;

    // Writable masks; reserved bits stay zero
    localparam logic [7:0] ACD_MASK_CS      = 8'hd7;
    localparam logic [7:0] ACD_MASK_SEL     = 8'h33;
    localparam logic [7:0] ACD_MASK_DAC     = 8'hff;
    localparam logic [7:0] ACD_MASK_PAD     = 8'h07;

    // Input routing codes
    typedef enum logic [1:0] {
        ACD_IN_EXT0 = 2'h0,
        ACD_IN_EXT1 = 2'h1,
        ACD_IN_EXT2 = 2'h2,
        ACD_IN_DAC  = 2'h3
    } acd_input_t;

    // Edge sensitivity codes
    localparam logic [1:0] ACD_MODE_FALL0 = 2'h0;
    localparam logic [1:0] ACD_MODE_RISE  = 2'h1;
    localparam logic [1:0] ACD_MODE_FALL2 = 2'h2;
    localparam logic [1:0] ACD_MODE_BOTH  = 2'h3;

endpackage

// ### acd_comparator_ctrl.sv
// Register file and event logic of the analog comparator with reference DAC
// Function
// R01 - Positive select 00/01/10 routes external input 0/1/2, 11 routes DAC.
// R02 - Negative select uses identical coding for the negative comparator input.
// R03 - Reserved bits of input select and pad enable read zero, ignore writes.
// R04 - DAC control bit 7 turns the reference DAC on or off.
// R05 - DAC control bit 6 picks bandgap (0) or analog supply (1).
// R06 - Six-bit level code sets DAC output to reference times (code+1)/64.
// R07 - Three pad bits each allow one external input pad to drive.
// R08 - Edge mode 00 or 10 counts only falling edges.
// R09 - Edge mode 01 counts only rising edges.
// R10 - Edge mode 11 counts both rising and falling edges.
// R11 - Valid edge sets event flag; interrupt raised when enable also set.
// R12 - Event flag holds until software writes zero to it.
// R13 - Raw comparator output synchronised to bus clock gives status bit.
// R14 - In stop mode status bit freezes, updates again after wake.
// R15 - In stop mode a valid edge raises a wake interrupt.
// R16 - Reset returns default setup with comparator and DAC off.
// R17 - Software configures DAC before enabling comparator when DAC feeds it.
// R18 - Software selects inputs before enabling, keeps them fixed while on.
// R19 - Software writes DAC level before enabling the DAC.
// R20 - Software sets pad enable for any selected external input.
// R21 - Comparator output reaches pin only while output pin enable set.
// R22 - Control bit 7 enables the comparator.
// R23 - Control bit 4 enables the comparator interrupt.
// R24 - Writing one to the event flag leaves it unchanged.
// R25 - Status bit resets to zero and reads zero while comparator disabled.
// R26 - Edge found by comparing status with its value one clock earlier.
`timescale 1ns/1ns
`default_nettype none

module acd_comparator_ctrl
    import acd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Power controller
    input  wire logic        stop_mode_i,
    // Analog side
    input  wire logic        raw_compare_out_i,
    output logic             comparator_enable_o,
    output logic             hysteresis_select_o,
    output logic      [1:0]  positive_input_select_o,
    output logic      [1:0]  negative_input_select_o,
    output logic             reference_dac_enable_o,
    output logic             reference_source_select_o,
    output logic      [5:0]  reference_level_code_o,
    output logic      [2:0]  input_pad_enable_o,
    output logic             compare_pin_o,
    output logic             compare_pin_oe_o,
    // Interrupts
    output logic             irq_o,
    output logic             wake_irq_o
);

    // Register storage
    // Status bit 3 is never stored; rebuilt on read
    logic [7:0] cs_reg;
    logic [7:0] sel_reg;
    logic [7:0] dac_reg;
    logic [7:0] pad_reg;

    // Bus phase and answer
    logic        pready_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    // Comparator output path
    // Stop-mode watch kept apart from status path
    logic sync1_reg;
    logic sync2_reg;
    logic synced_compare_out_reg;
    logic prev_out_reg;
    logic enabled_prev_reg;
    logic edge_event;
    logic wake_prev_reg;
    logic wake_event;

    // Outputs registered once more
    // Keeps every port straight off a flop
    logic irq_reg;
    logic wake_irq_reg;
    logic pin_reg;
    logic pin_oe_reg;

    // Decoded access strobes
    logic access_done;
    logic wr_done;
    logic addr_hit;
    logic [1:0] addr_idx;
    logic [7:0] wr_byte;
    logic flag_clear;

    // Valid edge test for one pair of samples
    // Modes 00 and 10 share the falling decode
    function automatic logic valid_edge(
        input logic [1:0] mode,
        input logic       prev,
        input logic       cur
    );
        logic rise;
        logic fall;
        rise = ~prev & cur;
        fall = prev & ~cur;
        case (mode)
            ACD_MODE_RISE: valid_edge = rise;           // [R09]
            ACD_MODE_BOTH: valid_edge = rise | fall;    // [R10]
            default:       valid_edge = fall;           // [R08]
        endcase
    endfunction

    // Address decode of a word-aligned register index
    // A miss answers with an error, never a write
    function automatic logic decode_hit(
        input  logic [11:0] addr
    );
        decode_hit = (addr == ACD_ADDR_CTRL_STATUS) ||
                     (addr == ACD_ADDR_INPUT_SEL)   ||
                     (addr == ACD_ADDR_DAC_CTRL)    ||
                     (addr == ACD_ADDR_PAD_EN);
    endfunction

    // Read view of the register selected by index
    // Reserved bits masked here as well as on write
    function automatic logic [7:0] read_view(
        input logic [1:0] idx,
        input logic [7:0] cs,
        input logic [7:0] sel,
        input logic [7:0] dac,
        input logic [7:0] pad,
        input logic       status
    );
        logic [7:0] v;
        v = 8'h00;
        if (idx == ACD_IDX_CTRL_STATUS) begin
            // Flag is not writable but must read back
            v = cs;
            v[ACD_CS_OUT_BIT] = status;
        end else if (idx == ACD_IDX_INPUT_SEL) begin
            v = sel & ACD_MASK_SEL;                     // [R03]
        end else if (idx == ACD_IDX_DAC_CTRL) begin
            v = dac & ACD_MASK_DAC;
        end else begin
            v = pad & ACD_MASK_PAD;                     // [R03]
        end
        read_view = v;
    endfunction

    // Request decode; a write lands only at the edge that sees pready
    // Only byte lane 0 holds register bits
    always_comb begin
        addr_hit    = decode_hit(paddr_i);
        addr_idx    = paddr_i[3:2];
        access_done = psel_i & penable_i & pready_reg;
        wr_done     = access_done & pwrite_i & addr_hit & pstrb_i[0];
        wr_byte     = pwdata_i[7:0];
        flag_clear  = wr_done && (addr_idx == ACD_IDX_CTRL_STATUS) &&
                      !wr_byte[ACD_CS_FLAG_BIT];        // [R12] [R24]
    end

    // One wait state: answer prepared in the first access cycle
    // Read data is a snapshot, steady with pready
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (access_done) begin
                pready_reg  <= 1'b0;
                pslverr_reg <= 1'b0;
            end else if (psel_i && penable_i) begin
                pready_reg  <= 1'b1;
                pslverr_reg <= ~addr_hit;
                prdata_reg  <= {24'h000000, addr_hit ?
                               read_view(addr_idx, cs_reg, sel_reg, dac_reg,
                                         pad_reg, synced_compare_out_reg)
                               : 8'h00};
            end
        end
    end

    // Control and status register; flag set wins over a clear
    // So an edge meeting the clear is never lost
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cs_reg <= ACD_RESET_VALUE;                  // [R16]
        end else if (clk_en_i) begin
            if (wr_done && (addr_idx == ACD_IDX_CTRL_STATUS)) begin
                cs_reg[ACD_CS_ENABLE_BIT] <= wr_byte[ACD_CS_ENABLE_BIT]; // [R22]
                cs_reg[ACD_CS_HYST_BIT]   <= wr_byte[ACD_CS_HYST_BIT];
                cs_reg[ACD_CS_IRQEN_BIT]  <= wr_byte[ACD_CS_IRQEN_BIT];  // [R23]
                cs_reg[ACD_CS_OPE_BIT]    <= wr_byte[ACD_CS_OPE_BIT];
                cs_reg[ACD_CS_MODE_LSB +: 2] <= wr_byte[ACD_CS_MODE_LSB +: 2];
            end
            if (edge_event) begin
                cs_reg[ACD_CS_FLAG_BIT] <= 1'b1;        // [R11]
            end else if (flag_clear) begin
                cs_reg[ACD_CS_FLAG_BIT] <= 1'b0;        // [R12]
            end
        end
    end

    // Input select; reserved bits never stored
    // Changing it while enabled may glitch the output
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_reg <= ACD_RESET_VALUE;
        end else if (clk_en_i) begin
            if (wr_done && (addr_idx == ACD_IDX_INPUT_SEL)) begin
                sel_reg <= wr_byte & ACD_MASK_SEL;      // [R03]
            end
        end
    end

    // DAC control; the level code may be written while the DAC is on
    // The output then needs time to settle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dac_reg <= ACD_RESET_VALUE;                 // [R16]
        end else if (clk_en_i) begin
            if (wr_done && (addr_idx == ACD_IDX_DAC_CTRL)) begin
                dac_reg <= wr_byte & ACD_MASK_DAC;
            end
        end
    end

    // Pad enables
    // A blocked pad keeps its level off the inputs
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pad_reg <= ACD_RESET_VALUE;
        end else if (clk_en_i) begin
            if (wr_done && (addr_idx == ACD_IDX_PAD_EN)) begin
                pad_reg <= wr_byte & ACD_MASK_PAD;      // [R03]
            end
        end
    end

    // Two-flop synchroniser for the raw comparator output
    // Only stage two feeds logic; stage one may be metastable
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (clk_en_i) begin
            sync1_reg <= raw_compare_out_i;             // [R13]
            sync2_reg <= sync1_reg;
        end
    end

    // Status bit: zero while disabled, frozen during stop
    // Catches up at the first cycle after stop
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            synced_compare_out_reg <= 1'b0;             // [R25]
        end else if (clk_en_i) begin
            if (!cs_reg[ACD_CS_ENABLE_BIT]) begin
                synced_compare_out_reg <= 1'b0;         // [R25]
            end else if (!stop_mode_i) begin
                synced_compare_out_reg <= sync2_reg;    // [R13] [R14]
            end
        end
    end

    // History for edge detection; enable history masks the first enabled cycle only, so the turn-on step still counts
    // The older sample may still be the zero loaded while disabled
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev_out_reg     <= 1'b0;
            enabled_prev_reg <= 1'b0;
        end else if (clk_en_i) begin
            prev_out_reg     <= synced_compare_out_reg; // [R26]
            enabled_prev_reg <= cs_reg[ACD_CS_ENABLE_BIT];
        end
    end

    // Single-cycle valid edge while enabled on both samples
    // Lags the raw output by three clocks
    always_comb begin
        edge_event = cs_reg[ACD_CS_ENABLE_BIT] & enabled_prev_reg &
                     valid_edge(cs_reg[ACD_CS_MODE_LSB +: 2],
                                prev_out_reg, synced_compare_out_reg); // [R26]
    end

    // Stop-mode edge watch runs on the synchroniser, not the frozen status
    // Own history, so the freeze cannot hide edges
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wake_prev_reg <= 1'b0;
        end else if (clk_en_i) begin
            wake_prev_reg <= sync2_reg;
        end
    end

    // Wake edge counts only in stop with comparator on
    always_comb begin
        wake_event = stop_mode_i & cs_reg[ACD_CS_ENABLE_BIT] &
                     valid_edge(cs_reg[ACD_CS_MODE_LSB +: 2],
                                wake_prev_reg, sync2_reg); // [R15]
    end

    // Wake request held until flag cleared; a new edge beats the clear
    // A level, so a sleeping core cannot miss it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wake_irq_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (wake_event) begin
                wake_irq_reg <= 1'b1;                   // [R15]
            end else if (flag_clear) begin
                wake_irq_reg <= 1'b0;
            end
        end
    end

    // CPU interrupt: flag gated by enable
    // Registered, so it lags the flag by one clock
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_reg <= 1'b0;
        end else if (clk_en_i) begin
            irq_reg <= cs_reg[ACD_CS_FLAG_BIT] & cs_reg[ACD_CS_IRQEN_BIT]; // [R11]
        end
    end

    // Output pin follows status only while the output pin enable bit is set
    // Data and enable share one stage and move together
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_reg    <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else if (clk_en_i) begin
            pin_oe_reg <= cs_reg[ACD_CS_OPE_BIT];       // [R21]
            pin_reg    <= cs_reg[ACD_CS_OPE_BIT] & synced_compare_out_reg; // [R21]
        end
    end

    // Bus answer
    // All three straight from flip-flops
    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;

    // Analog controls straight from the register bits
    // No extra stage; the analog side settles anyway
    assign comparator_enable_o       = cs_reg[ACD_CS_ENABLE_BIT];       // [R22]
    assign hysteresis_select_o       = cs_reg[ACD_CS_HYST_BIT];
    assign positive_input_select_o   = sel_reg[ACD_SEL_POS_LSB +: 2];   // [R01]
    assign negative_input_select_o   = sel_reg[ACD_SEL_NEG_LSB +: 2];   // [R02]
    assign reference_dac_enable_o    = dac_reg[ACD_DAC_EN_BIT];         // [R04]
    assign reference_source_select_o = dac_reg[ACD_DAC_REF_BIT];        // [R05]
    assign reference_level_code_o    = dac_reg[ACD_DAC_CODE_LSB +: 6];  // [R06]
    assign input_pad_enable_o        = pad_reg[ACD_PAD_LSB +: 3];       // [R07]

    // Pin and interrupts
    // Registered above, passed out unchanged
    assign compare_pin_o    = pin_reg;
    assign compare_pin_oe_o = pin_oe_reg;
    assign irq_o            = irq_reg;
    assign wake_irq_o       = wake_irq_reg;

endmodule

`default_nettype wire

// ### acd_amod.sv
// Behavioural model of the comparator core, reference DAC and input pads
`timescale 1ns/1ns
`default_nettype none
module acd_amod (
    input  wire logic             enable_i,
    input  wire logic [1:0]       pos_sel_i,
    input  wire logic [1:0]       neg_sel_i,
    input  wire logic             dac_en_i,
    input  wire logic             dac_ref_i,
    input  wire logic [5:0]       dac_code_i,
    input  wire logic [2:0]       pad_en_i,
    input  wire logic [2:0][11:0] ext_i,
    output logic                  cmp_o
);
    logic [11:0] dac_lvl;
    logic [11:0] pos_lvl;
    logic [11:0] neg_lvl;
    // Levels in millivolts; a blocked pad reads as ground, not as the pin
    always_comb begin
        dac_lvl = dac_en_i ? 12'(((dac_ref_i ? 3300 : 1200) * (dac_code_i + 7'd1)) / 64) : 12'h000;
        pos_lvl = (pos_sel_i == 2'h3) ? dac_lvl : (pad_en_i[pos_sel_i] ? ext_i[pos_sel_i] : 12'h000);
        neg_lvl = (neg_sel_i == 2'h3) ? dac_lvl : (pad_en_i[neg_sel_i] ? ext_i[neg_sel_i] : 12'h000);
        cmp_o   = enable_i && (pos_lvl > neg_lvl);
    end
endmodule
`default_nettype wire

// ### acd_chk_asserts.sv
// Port checks of the comparator control block
`timescale 1ns/1ns
`default_nettype none
module acd_chk
    import acd_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        clk_en_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        stop_mode_i,
    input wire logic        raw_compare_out_i,
    input wire logic        comparator_enable_o,
    input wire logic [1:0]  positive_input_select_o,
    input wire logic [1:0]  negative_input_select_o,
    input wire logic        reference_dac_enable_o,
    input wire logic        reference_source_select_o,
    input wire logic [5:0]  reference_level_code_o,
    input wire logic [2:0]  input_pad_enable_o,
    input wire logic        compare_pin_o,
    input wire logic        compare_pin_oe_o,
    input wire logic        irq_o,
    input wire logic        wake_irq_o
);
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic       done;
    logic       rd;
    logic       wr;
    logic [7:0] wd_q;
    // Completion edge of a transfer; a write lands only here
    assign done = psel_i && penable_i && pready_o && clk_en_i;
    assign rd   = done && !pwrite_i;
    assign wr   = done && pwrite_i && pstrb_i[0];
    // Written byte held a cycle for the field comparisons
    always_ff @(posedge clk_i) begin
        wd_q <= pwdata_i[7:0];
    end
    a_select_update : assert property (wr && paddr_i == ACD_ADDR_INPUT_SEL |=>
        {positive_input_select_o, negative_input_select_o} == {wd_q[5:4], wd_q[1:0]})
        else $error("input selects differ from written byte");
    a_reserved_zero : assert property (rd |-> prdata_o[31:8] == 24'h0 &&
        (paddr_i != ACD_ADDR_INPUT_SEL || (prdata_o[7:0] & 8'hcc) == 8'h00) &&
        (paddr_i != ACD_ADDR_PAD_EN || prdata_o[7:3] == 5'h00)) else $error("reserved bits read nonzero");
    a_dac_update : assert property (wr && paddr_i == ACD_ADDR_DAC_CTRL |=>
        {reference_dac_enable_o, reference_source_select_o, reference_level_code_o} == wd_q)
        else $error("DAC outputs differ from written byte");
    a_pad_update : assert property (wr && paddr_i == ACD_ADDR_PAD_EN |=> input_pad_enable_o == wd_q[2:0])
        else $error("pad enables differ from written byte");
    a_status_off : assert property (rd && paddr_i == ACD_ADDR_CTRL_STATUS && !comparator_enable_o &&
        !$past(comparator_enable_o, 2) |-> !prdata_o[3]) else $error("status bit set while disabled");
    a_pin_gated : assert property (compare_pin_o |-> compare_pin_oe_o || $past(compare_pin_oe_o))
        else $error("pin driven without pin enable");
    a_reset_default : assert property ($fell(sys_rst_i) |-> !comparator_enable_o && !reference_dac_enable_o)
        else $error("comparator or DAC on after reset");
    a_edge_irq : assert property ($rose(irq_o) |->
        $past(raw_compare_out_i, 5) != $past(raw_compare_out_i, 6) || $past(wr, 2)) else $error("irq without edge");
    a_wake_stop : assert property ($rose(wake_irq_o) |-> stop_mode_i || $past(stop_mode_i))
        else $error("wake irq outside stop");
    // Main scenarios reached
    c_irq : cover property ($rose(irq_o));
    c_wake : cover property ($rose(wake_irq_o));
    c_pin : cover property (compare_pin_o);
endmodule
bind acd_comparator_ctrl acd_chk acd_chk_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .stop_mode_i(stop_mode_i),
    .raw_compare_out_i(raw_compare_out_i), .comparator_enable_o(comparator_enable_o),
    .positive_input_select_o(positive_input_select_o), .negative_input_select_o(negative_input_select_o),
    .reference_dac_enable_o(reference_dac_enable_o), .reference_source_select_o(reference_source_select_o),
    .reference_level_code_o(reference_level_code_o), .input_pad_enable_o(input_pad_enable_o),
    .compare_pin_o(compare_pin_o), .compare_pin_oe_o(compare_pin_oe_o), .irq_o(irq_o), .wake_irq_o(wake_irq_o));
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import acd_pkg::*;
    logic             clk_i = 1'b0;
    logic             sys_rst_i = 1'b1;
    logic             psel_i = 1'b0;
    logic             penable_i = 1'b0;
    logic             pwrite_i = 1'b0;
    logic             stop_i = 1'b0;
    logic [11:0]      paddr_i = 12'h000;
    logic [31:0]      pwdata_i = 32'h0;
    logic [2:0][11:0] ext = {12'h000, 12'h800, 12'h3e8};
    logic [31:0]      prdata_o, rdv;
    logic             rdy, err, erv, raw, cen, den, dref, pin, pin_oe, irq, wake, hyst;
    logic [1:0]       pos, neg;
    logic [5:0]       code;
    logic [2:0]       pad;
    int               err_total = 0;
    int               checked = 0;
    // Rows: address, write byte, read back {error, byte}, ports {pos, neg, dac en, ref, code, pads}
    logic [11:0]      t_adr [7] = '{12'h004, 12'h004, 12'h004, 12'h004, 12'h008, 12'h00c, 12'h010};
    logic [7:0]       t_dat [7] = '{8'hff, 8'h20, 8'h13, 8'h01, 8'hc5, 8'hff, 8'h5a};
    logic [8:0]       t_rd [7] = '{9'h033, 9'h020, 9'h013, 9'h001, 9'h0c5, 9'h007, 9'h100};
    logic [14:0]      t_out [7] = '{15'h7800, 15'h4000, 15'h3800, 15'h0800, 15'h0e28, 15'h0e2f, 15'h0e2f};
    always #10 clk_i = ~clk_i;
    acd_comparator_ctrl acd_comparator_ctrl_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(rdy), .pslverr_o(err), .stop_mode_i(stop_i),
        .raw_compare_out_i(raw), .comparator_enable_o(cen), .hysteresis_select_o(hyst), .positive_input_select_o(pos),
        .negative_input_select_o(neg), .reference_dac_enable_o(den), .reference_source_select_o(dref),
        .reference_level_code_o(code), .input_pad_enable_o(pad), .compare_pin_o(pin), .compare_pin_oe_o(pin_oe),
        .irq_o(irq), .wake_irq_o(wake));
    acd_amod acd_amod_inst (.enable_i(cen), .pos_sel_i(pos), .neg_sel_i(neg), .dac_en_i(den), .dac_ref_i(dref),
        .dac_code_i(code), .pad_en_i(pad), .ext_i(ext), .cmp_o(raw));
    // Verdict and end of run
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            complete_run();
        end
        rdv = prdata_o;
        erv = err;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Sets the positive pad level, then lets sync and flag logic settle
    task automatic drive(input logic [11:0] lvl);
        ext[0] <= lvl;
        repeat (8) @(posedge clk_i);
        apb(1'b0, ACD_ADDR_CTRL_STATUS, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * ACD_ADDR_SCALE), 8'h00);
            chk(rdv, 32'(ACD_RESET_VALUE));
        end
        chk(32'({cen, den}), 32'h0);
        $display("test reset done");
        // Selects, DAC and pads set before the comparator is enabled
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, t_adr[i], t_dat[i]);
            apb(1'b0, t_adr[i], 8'h00);
            chk(32'({erv, rdv[7:0]}), 32'(t_rd[i]));
            chk(32'({pos, neg, den, dref, code, pad}), 32'(t_out[i]));
        end
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ACD_ADDR_CTRL_STATUS, 8'h90 | 8'(m));
            drive(12'hbb8);
            chk(32'({rdv[5], irq, rdv[3]}), 32'({m[0], m[0], 1'b1}));
            apb(1'b1, ACD_ADDR_CTRL_STATUS, 8'hb0 | 8'(m));
            apb(1'b0, ACD_ADDR_CTRL_STATUS, 8'h00);
            chk(32'(rdv[5]), 32'(m[0]));
            apb(1'b1, ACD_ADDR_CTRL_STATUS, 8'h90 | 8'(m));
            drive(12'h3e8);
            chk(32'({rdv[5], irq, rdv[3]}), 32'({m != 1, m != 1, 1'b0}));
        end
        $display("test edge modes done");
        apb(1'b1, ACD_ADDR_CTRL_STATUS, 8'h83);
        stop_i <= 1'b1;
        drive(12'hbb8);
        chk(32'({wake, rdv[3]}), 32'h2);
        stop_i <= 1'b0;
        drive(12'hbb8);
        chk(32'({rdv[5], rdv[3]}), 32'h3);
        apb(1'b1, ACD_ADDR_CTRL_STATUS, 8'h83);
        @(posedge clk_i);
        chk(32'(wake), 32'h0);
        $display("test stop done");
        apb(1'b1, ACD_ADDR_CTRL_STATUS, 8'h84);
        repeat (2) @(posedge clk_i);
        chk(32'({pin, pin_oe}), 32'h3);
        apb(1'b1, ACD_ADDR_CTRL_STATUS, 8'h80);
        repeat (2) @(posedge clk_i);
        chk(32'({pin, pin_oe}), 32'h0);
        apb(1'b1, ACD_ADDR_CTRL_STATUS, 8'h40);
        apb(1'b0, ACD_ADDR_CTRL_STATUS, 8'h00);
        chk(32'({rdv[7], rdv[6], rdv[3], cen, hyst}), 32'h09);
        $display("test pin and disable done");
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(32'({den, pad, pos, hyst}), 32'h0);
        sys_rst_i <= 1'b0;
        $display("test second reset done");
        complete_run();
    end
endmodule
`default_nettype wire
